// *** timer3_capture_and_control_bench.sv ***
// self-checking bench for the timer three capture block
// assumes the cpu model is the only sfr master
`timescale 1ns/1ps
module timer3_capture_and_control_bench;
  import tmr_pkg::*;
  logic clk = 0, rst_n = 0, count_tick = 0, usb_sof = 0, slow_internal_osc = 0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, count_high, count_low, reload_high, reload_low, rd;
  logic sfr_wr, timer_irq_enable, ext_clock_select, timer_irq;
  logic [15:0] v, r;
  int failures = 0, n_compared = 0, seed = 60865, n, lo;
  always #2.5 clk = ~clk;
  tmr_cpu_model cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rdata(sfr_rdata), .timer_irq_enable(timer_irq_enable));
  tmr_capture uut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rdata(sfr_rdata), .count_tick(count_tick), .usb_sof(usb_sof), .slow_internal_osc(slow_internal_osc),
    .timer_irq_enable(timer_irq_enable), .count_high(count_high), .count_low(count_low),
    .reload_high(reload_high), .reload_low(reload_low), .ext_clock_select(ext_clock_select),
    .timer_irq(timer_irq));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // random ticks; dense forces one every cycle for the long wrap
  task automatic ticks(input int cnt, input logic dense, output int k);
    logic t;
    k = 0;
    repeat (cnt) begin
      @(posedge clk);
      t = dense | $random(seed);
      count_tick <= t;
      k += t;
    end
    @(posedge clk);
    count_tick <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // expected count words, one for each counting mode
  function automatic logic [15:0] wide_add(input logic [15:0] c, input int k);
    return c + k[15:0];
  endfunction
  function automatic logic [15:0] split_add(input logic [15:0] c, input int k);
    return {8'(c[15:8] + k[7:0]), 8'(c[7:0] + k[7:0])};
  endfunction
  // one source edge; exp_n request strobes and reload word exp_r expected
  task automatic capture(input logic src, input logic [15:0] exp_n, input logic [15:0] exp_r);
    logic [15:0] hits;
    hits = 16'h0000;
    @(posedge clk);
    if (src) slow_internal_osc <= 1'b1;
    else usb_sof <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      #1 hits = hits + {15'h0000, timer_irq};
    end
    chk({reload_high, reload_low}, exp_r);
    chk(hits, exp_n);
    @(posedge clk);
    usb_sof <= 1'b0;
    slow_internal_osc <= 1'b0;
  endtask
  initial begin
    #450000;
    failures++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cpu.rd_reg(TMR_CTRL_ADDR, rd);
    chk(rd, TMR_CTRL_RESET);
    cpu.wr_reg(TMR_CTRL_ADDR, 8'hff);
    cpu.wr_reg(8'h90, 8'h00);
    cpu.rd_reg(TMR_CTRL_ADDR, rd);
    chk({rd, 7'h00, ext_clock_select}, 16'h3f01);
    cpu.irq_en(1'b1);
    cpu.wr_reg(TMR_CTRL_ADDR, 8'h38);
    ticks(600, 1'b0, n);
    chk({count_high, count_low}, {8'h00, n[7:0]});
    cpu.rd_reg(TMR_CTRL_ADDR, rd);
    chk({rd, 7'h00, timer_irq}, {1'b0, n >= 256, 6'h38, 7'h00, n >= 256});
    lo = n % 256;
    cpu.irq_en(1'b0);
    repeat (2) @(posedge clk);
    #1 chk(timer_irq, 1'b0);
    cpu.wr_reg(TMR_CTRL_ADDR, 8'h3c);
    ticks(600, 1'b0, n);
    v = split_add({8'h00, lo[7:0]}, n);
    chk({count_high, count_low}, v);
    cpu.rd_reg(TMR_CTRL_ADDR, rd);
    chk(rd, {n >= 256, (lo + n) >= 256, 6'h3c});
    cpu.wr_reg(TMR_CTRL_ADDR, 8'h34);
    ticks(65536, 1'b1, n);
    v = wide_add(v, n);
    chk({count_high, count_low}, v);
    cpu.rd_reg(TMR_CTRL_ADDR, rd);
    chk(rd, 8'hf4);
    cpu.irq_en(1'b1);
    repeat (2) @(posedge clk);
    #1 chk(timer_irq, 1'b1);
    // each write also clears the flags, so only capture strobes reach timer_irq
    cpu.wr_reg(TMR_CTRL_ADDR, 8'h34);
    capture(1'b0, 16'h0001, v);
    r = v;
    ticks(200, 1'b0, n);
    v = wide_add(v, n);
    chk({count_high, count_low}, v);
    cpu.wr_reg(TMR_CTRL_ADDR, 8'h34);
    capture(1'b1, 16'h0000, r);
    cpu.wr_reg(TMR_CTRL_ADDR, 8'h36);
    capture(1'b0, 16'h0000, r);
    capture(1'b1, 16'h0001, v);
    r = v;
    ticks(200, 1'b0, n);
    v = wide_add(v, n);
    cpu.wr_reg(TMR_CTRL_ADDR, 8'h26);
    capture(1'b1, 16'h0000, r);
    capture(1'b0, 16'h0000, r);
    cpu.wr_reg(TMR_CTRL_ADDR, 8'h3c);
    ticks(100, 1'b0, n);
    v = split_add(v, n);
    chk({count_high, count_low}, v);
    cpu.wr_reg(TMR_CTRL_ADDR, 8'h3c);
    capture(1'b0, 16'h0001, v);
    cpu.irq_en(1'b0);
    capture(1'b0, 16'h0000, v);
    end_sim;
  end
endmodule // timer3_capture_and_control_bench

// *** tmr_capture.sv ***
// timer three counter, capture path and control register
// assumes the cpu writes the control register one byte per strobe
// and that count_tick is a one-cycle tick from the clock divider
`timescale 1ns/1ps
// How it works
// - split mode runs two independent 8-bit counters
// - capture copies count bytes into reload bytes
// - capture raises interrupt only when enabled
// - high flag set on high byte wrap
// - sixteen-bit wrap sets the high flag
// - set high flag plus enable requests interrupt
// - hardware never clears flags; software writes zero
// - low flag at bit 6 on low wrap
// - low interrupt needs bit 5 and enable
// - control register at 0x91, resets zero
// - capture enable selects capture mode
// - source select picks sof or slow oscillator
// - non-split capture counts as one 16-bit counter
// - run gates high byte; low always counts split
module tmr_capture (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // special function register bus
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  output logic [7:0]      sfr_rdata,
  // counting and capture sources
  input  wire logic       count_tick,
  input  wire logic       usb_sof,
  input  wire logic       slow_internal_osc,
  input  wire logic       timer_irq_enable,
  // results
  output logic [7:0]      count_high,
  output logic [7:0]      count_low,
  output logic [7:0]      reload_high,
  output logic [7:0]      reload_low,
  output logic            ext_clock_select,
  output logic            timer_irq
);
  import tmr_pkg::*;

  logic [7:0] ctrl_reg;
  logic       sof_pulse;
  logic       osc_pulse;
  logic       capture;
  logic       inc_low;
  logic       inc_high;
  logic       wrap_low;
  logic       wrap_high;
  logic       ctrl_wr;
  logic       high_overflow_flag;
  logic       low_overflow_flag;
  logic       low_byte_irq_enable;
  logic       capture_enable;
  logic       split_mode;
  logic       run_control;
  logic       capture_source_select;

  assign high_overflow_flag    = ctrl_reg[TMR_BIT_HFLAG];
  assign low_overflow_flag     = ctrl_reg[TMR_BIT_LFLAG];
  assign low_byte_irq_enable   = ctrl_reg[TMR_BIT_LIRQEN];
  assign capture_enable        = ctrl_reg[TMR_BIT_CAPEN];
  assign split_mode            = ctrl_reg[TMR_BIT_SPLIT];
  assign run_control           = ctrl_reg[TMR_BIT_RUN];
  assign capture_source_select = ctrl_reg[TMR_BIT_CAPSEL];
  assign ctrl_wr               = sfr_wr && (sfr_addr == TMR_CTRL_ADDR);

  tmr_edge_sync u_sof_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (usb_sof),
    .pulse    (sof_pulse)
  );

  tmr_edge_sync u_osc_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (slow_internal_osc),
    .pulse    (osc_pulse)
  );

  assign capture  = capture_enable && (capture_source_select ? osc_pulse : sof_pulse);

  // low byte free-runs only in split mode
  assign inc_low  = count_tick && (split_mode || run_control);
  assign wrap_low = inc_low && (count_low == TMR_BYTE_MAX);
  // in 16-bit mode the high byte steps on the low carry
  assign inc_high  = split_mode ? (count_tick && run_control) : wrap_low;
  assign wrap_high = inc_high && (count_high == TMR_BYTE_MAX);

  // counters; auto-reload modes live elsewhere, so the count just wraps
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_low  <= TMR_BYTE_ZERO;
      count_high <= TMR_BYTE_ZERO;
    end else begin
      if (inc_low)
        count_low <= count_low + 8'h01;
      if (inc_high)
        count_high <= count_high + 8'h01;
    end
  end

  // capture copies the value seen before this edge's increment
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reload_low  <= TMR_BYTE_ZERO;
      reload_high <= TMR_BYTE_ZERO;
    end else if (capture) begin
      reload_low  <= count_low;
      reload_high <= count_high;
    end
  end

  // control register; flags accept only software zeros
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg <= TMR_CTRL_RESET;
    end else begin
      if (ctrl_wr)
        ctrl_reg[5:0] <= sfr_wdata[5:0];
      if (wrap_high)
        ctrl_reg[TMR_BIT_HFLAG] <= 1'b1;
      else if (ctrl_wr && !sfr_wdata[TMR_BIT_HFLAG])
        ctrl_reg[TMR_BIT_HFLAG] <= 1'b0;
      if (wrap_low)
        ctrl_reg[TMR_BIT_LFLAG] <= 1'b1;
      else if (ctrl_wr && !sfr_wdata[TMR_BIT_LFLAG])
        ctrl_reg[TMR_BIT_LFLAG] <= 1'b0;
    end
  end

  // capture is a pulse, so its request is a one-cycle strobe on top of the flags
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_irq        <= 1'b0;
      sfr_rdata        <= TMR_BYTE_ZERO;
      ext_clock_select <= 1'b0;
    end else begin
      timer_irq <= timer_irq_enable && (high_overflow_flag
                   || (low_overflow_flag && low_byte_irq_enable)
                   || capture);
      if (sfr_addr == TMR_CTRL_ADDR)
        sfr_rdata <= ctrl_reg;
      else
        sfr_rdata <= TMR_BYTE_ZERO;
      ext_clock_select <= ctrl_reg[TMR_BIT_XCLK];
    end
  end

  a_capture_copy: assert property (@(posedge clk) disable iff (!rst_n)
    capture |=> (reload_low == $past(count_low)) && (reload_high == $past(count_high)))
    else $error("capture did not copy count");

  a_capture_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !capture |=> $stable(reload_low) && $stable(reload_high))
    else $error("reload changed without capture");

  a_capture_off: assert property (@(posedge clk) disable iff (!rst_n)
    !capture_enable |=> $stable(reload_low) && $stable(reload_high))
    else $error("capture while capture mode off");

  a_source_select: assert property (@(posedge clk) disable iff (!rst_n)
    capture_enable && capture_source_select && !osc_pulse |=> $stable(reload_low) && $stable(reload_high))
    else $error("unselected source captured");

  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    high_overflow_flag && !(ctrl_wr && !sfr_wdata[TMR_BIT_HFLAG]) |=> high_overflow_flag)
    else $error("high flag cleared without write");

  a_low_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !low_overflow_flag && !wrap_low |=> !low_overflow_flag)
    else $error("low flag set without wrap");

  a_high_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    wrap_high |=> high_overflow_flag && count_high == TMR_BYTE_ZERO)
    else $error("high wrap did not set flag");

  a_low_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    wrap_low |=> low_overflow_flag && count_low == TMR_BYTE_ZERO)
    else $error("low wrap did not set flag");

  a_split_high_hold: assert property (@(posedge clk) disable iff (!rst_n)
    split_mode && !run_control && !ctrl_wr |=> $stable(count_high))
    else $error("high byte ran while stopped");

  a_split_low_free: assert property (@(posedge clk) disable iff (!rst_n)
    split_mode && count_tick |=> count_low == $past(count_low) + 8'h01)
    else $error("low byte missed a split tick");

  a_wide_carry: assert property (@(posedge clk) disable iff (!rst_n)
    !split_mode && inc_low && count_low != TMR_BYTE_MAX |=> $stable(count_high))
    else $error("high byte stepped without carry");

  a_irq_high: assert property (@(posedge clk) disable iff (!rst_n)
    timer_irq_enable && high_overflow_flag |=> timer_irq)
    else $error("high flag did not request");

  a_irq_low_byte: assert property (@(posedge clk) disable iff (!rst_n)
    timer_irq_enable && low_overflow_flag && low_byte_irq_enable |=> timer_irq)
    else $error("low flag did not request");

  a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !high_overflow_flag && !low_byte_irq_enable && !capture |=> !timer_irq)
    else $error("request without an enabled source");

  a_irq_low_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !timer_irq_enable |=> !timer_irq)
    else $error("request while disabled");

  a_ctrl_write: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_wr |=> (ctrl_reg & 8'h3f) == ($past(sfr_wdata) & 8'h3f))
    else $error("control write did not land");

  a_read_data: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_addr == TMR_CTRL_ADDR |=> sfr_rdata == $past(ctrl_reg))
    else $error("control read returned wrong byte");

  a_one_capture: assert property (@(posedge clk) disable iff (!rst_n)
    sof_pulse |=> !sof_pulse)
    else $error("capture strobe longer than one cycle");

endmodule // tmr_capture

// *** tmr_cpu_model.sv ***
// cpu core model driving the timer's sfr bus
// assumes the bench calls its tasks, one access at a time
`timescale 1ns/1ps
module tmr_cpu_model (
  // clock
  input  wire logic       clk,
  // sfr bus
  output logic [7:0]      sfr_addr,
  output logic [7:0]      sfr_wdata,
  output logic            sfr_wr,
  input  wire logic [7:0] sfr_rdata,
  // interrupt enable
  output logic            timer_irq_enable
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    timer_irq_enable = 1'b0;
  end
  // flags are cleared only by writing zero here
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
    sfr_wdata <= ~d; // released data must not hold
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    @(posedge clk);
    #1 d = sfr_rdata;
  endtask
  task automatic irq_en(input logic e);
    @(posedge clk);
    timer_irq_enable <= e;
  endtask
endmodule // tmr_cpu_model

// *** tmr_edge_sync.sv ***
// synchroniser and rising-edge pulse for one capture source
// assumes the source is asynchronous to clk
`timescale 1ns/1ps
module tmr_edge_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // event
  input  wire logic async_in,
  output logic      pulse
);
  import tmr_pkg::*;
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      pulse    <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      pulse    <= sync_reg & ~last_reg;
    end
  end
endmodule // tmr_edge_sync

// *** tmr_pkg.sv ***
// package for the timer three capture and control block
// assumes an 8-bit special function register bus from the cpu core
package tmr_pkg;
  localparam logic [7:0] TMR_CTRL_ADDR   = 8'h91;
  localparam logic [7:0] TMR_CTRL_RESET  = 8'h00;
  localparam int         TMR_BIT_HFLAG   = 7;
  localparam int         TMR_BIT_LFLAG   = 6;
  localparam int         TMR_BIT_LIRQEN  = 5;
  localparam int         TMR_BIT_CAPEN   = 4;
  localparam int         TMR_BIT_SPLIT   = 3;
  localparam int         TMR_BIT_RUN     = 2;
  localparam int         TMR_BIT_CAPSEL  = 1;
  localparam int         TMR_BIT_XCLK    = 0;
  localparam logic [7:0] TMR_BYTE_MAX    = 8'hff;
  localparam logic [7:0] TMR_BYTE_ZERO   = 8'h00;
  localparam int         TMR_SYNC_STAGES = 2;
endpackage
